// ### hdl/sfsp_pkg.sv
// sfsp_pkg: shared constants for the flash status and protection block
// assumes: one 24-bit byte address space and 8-bit instruction codes
package sfsp_pkg;

   localparam int unsigned ADDR_W = 24;

   // instruction codes handled here
   localparam logic [7:0] OP_WREN       = 8'h06;
   localparam logic [7:0] OP_WRDI       = 8'h04;
   localparam logic [7:0] OP_RD_LO      = 8'h05;
   localparam logic [7:0] OP_RD_HI      = 8'h35;
   localparam logic [7:0] OP_WR_STAT    = 8'h01;
   localparam logic [7:0] OP_WR_HI      = 8'h31;
   localparam logic [7:0] OP_PROG       = 8'h02;
   localparam logic [7:0] OP_QPROG      = 8'h33;
   localparam logic [7:0] OP_ER_4K      = 8'h20;
   localparam logic [7:0] OP_ER_32K     = 8'h52;
   localparam logic [7:0] OP_ER_64K     = 8'hD8;
   localparam logic [7:0] OP_ER_CHIP_A  = 8'h60;
   localparam logic [7:0] OP_ER_CHIP_B  = 8'hC7;
   localparam logic [7:0] OP_SUSPEND    = 8'h75;
   localparam logic [7:0] OP_RESUME     = 8'h7A;
   localparam logic [7:0] OP_SECURE_WR  = 8'h2F;
   localparam logic [7:0] OP_FOUR_ON    = 8'h38;
   localparam logic [7:0] OP_FOUR_OFF   = 8'hFF;
   localparam logic [7:0] OP_QRD_OUT    = 8'h6B;
   localparam logic [7:0] OP_QRD_IO     = 8'hEB;
   localparam logic [7:0] OP_QRD_ID     = 8'h94;
   localparam logic [7:0] OP_QRD_WORD   = 8'hE7;
   localparam logic [7:0] OP_QWRAP      = 8'h77;

   // region masks (size minus one) per instruction
   localparam logic [23:0] MASK_PAGE    = 24'h00_00FF;
   localparam logic [23:0] MASK_4K      = 24'h00_0FFF;
   localparam logic [23:0] MASK_32K     = 24'h00_7FFF;
   localparam logic [23:0] MASK_64K     = 24'h00_FFFF;
   localparam logic [23:0] ADDR_MAX     = 24'hFF_FFFF;
   localparam logic [23:0] ADDR_ZERO    = 24'h00_0000;
   localparam logic [23:0] ONE_BYTE     = 24'h00_0001;
   localparam logic [23:0] BLK_UNIT     = 24'h04_0000;
   localparam logic [23:0] SECT_UNIT    = 24'h00_1000;
   localparam logic [23:0] SECT_CAP     = 24'h00_8000;

   // protect level codes
   localparam logic [2:0] LVL_NONE      = 3'h0;
   localparam logic [2:0] LVL_ONE       = 3'h1;
   localparam logic [2:0] LVL_SECT_MAX  = 3'h3;
   localparam logic [2:0] LVL_ALL       = 3'h7;

   // status write busy time
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SWR_TIME_NS   = 160;
   localparam int unsigned SWR_CYCLES    = (SWR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SWR_CNT_W     = $clog2(SWR_CYCLES + 1);

   typedef enum logic [1:0] {ST_IDLE, ST_ARRAY, ST_STATUS} sfsp_st_t;

endpackage

// ### hdl/sfsp_sync2.sv
// sfsp_sync2: two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous levels; ce_i freezes the stages
`timescale 1ns/10ps
module sfsp_sync2
   import sfsp_pkg::*;
#(
   parameter int unsigned W = 3
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sfsp_sync_t;

   sfsp_sync_t r;
   sfsp_sync_t next_r;

   // first stage feeds only the second stage
   always_comb begin
      next_r        = r;
      next_r.meta   = async_i;
      next_r.stable = r.meta;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign sync_o = r.stable;

endmodule

// ### hdl/sfsp_prot_range.sv
// sfsp_prot_range: maps the protect fields to one protected address interval
// assumes: protected area is always one contiguous run at either end
`timescale 1ns/10ps
module sfsp_prot_range
   import sfsp_pkg::*;
(
   input  wire logic        gran_i,
   input  wire logic        top_bottom_i,
   input  wire logic [2:0]  level_i,
   input  wire logic        invert_i,
   output logic             prot_any_o,
   output logic     [23:0]  prot_lo_o,
   output logic     [23:0]  prot_hi_o
);

   logic [23:0] size;
   logic        base_any;
   logic [23:0] base_lo;
   logic [23:0] base_hi;

   // size of the plain area: 256KB-block or 4KB-sector steps
   always_comb begin
      size = ADDR_ZERO;
      if (!gran_i) begin
         size = BLK_UNIT << (level_i - LVL_ONE);
      end else if (level_i <= LVL_SECT_MAX) begin
         size = SECT_UNIT << (level_i - LVL_ONE);
      end else begin
         size = SECT_CAP;
      end
   end

   // plain interval anchored at top or bottom
   always_comb begin
      base_any = (level_i != LVL_NONE);
      base_lo  = ADDR_ZERO;
      base_hi  = ADDR_MAX;
      if (level_i == LVL_ALL) begin
         base_lo = ADDR_ZERO;
         base_hi = ADDR_MAX;
      end else if (!top_bottom_i) begin
         base_lo = ADDR_ZERO - size;
         base_hi = ADDR_MAX;
      end else begin
         base_lo = ADDR_ZERO;
         base_hi = size - ONE_BYTE;
      end
   end

   // inversion swaps the interval for its complement
   always_comb begin
      prot_any_o = base_any;
      prot_lo_o  = base_lo;
      prot_hi_o  = base_hi;
      if (invert_i) begin
         if (level_i == LVL_NONE) begin
            prot_any_o = 1'b1;
            prot_lo_o  = ADDR_ZERO;
            prot_hi_o  = ADDR_MAX;
         end else if (level_i == LVL_ALL) begin
            prot_any_o = 1'b0;
         end else if (!top_bottom_i) begin
            prot_lo_o  = ADDR_ZERO;
            prot_hi_o  = base_lo - ONE_BYTE;
         end else begin
            prot_lo_o  = base_hi + ONE_BYTE;
            prot_hi_o  = ADDR_MAX;
         end
      end
   end

endmodule

// ### hdl/sfsp_core.sv
// sfsp_core: status registers, status-write locking and array protection
// assumes: an instruction decoder on core_clk_i hands over whole instructions;
// chip select, serial clock and write-guard arrive as raw pins
`timescale 1ns/10ps
module sfsp_core
   import sfsp_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cmd_valid_i,
   input  wire logic [7:0]  cmd_code_i,
   input  wire logic [23:0] cmd_addr_i,
   input  wire logic [15:0] cmd_data_i,
   input  wire logic        cmd_two_bytes_i,
   input  wire logic        op_done_i,
   input  wire logic        sclk_pin_i,
   input  wire logic        cs_n_pin_i,
   input  wire logic        write_guard_n_pin_i,
   output logic     [15:0]  status_o,
   output logic             array_start_o,
   output logic     [7:0]   array_op_o,
   output logic     [23:0]  array_addr_o,
   output logic             array_suspend_o,
   output logic             array_resume_o,
   output logic             cmd_ignored_o,
   output logic             four_lane_mode_o,
   output logic             so_o,
   output logic             so_oe_o
);

   typedef struct packed {
      sfsp_st_t               st;
      logic                   busy;
      logic                   wrlatch;
      logic [2:0]             level;
      logic                   top_bottom;
      logic                   gran;
      logic                   lock0;
      logic                   lock1;
      logic                   four_lane;
      logic                   invert;
      logic                   paused;
      logic [SWR_CNT_W-1:0]   wr_cnt;
      logic                   quad_cmds;
      logic                   sclk_q;
      logic                   rd_on;
      logic                   rd_hi;
      logic [2:0]             rd_idx;
      logic                   so;
      logic                   so_oe;
      logic                   start;
      logic [7:0]             op;
      logic [23:0]            addr;
      logic                   suspend;
      logic                   resume;
      logic                   ignored;
   } sfsp_core_t;

   // all-zero reset equals factory defaults and unlocked state
   localparam sfsp_core_t RESET_STATE = '0;

   sfsp_core_t  r;
   sfsp_core_t  next_r;
   logic [2:0]  pins_s;
   logic        sclk_s;
   logic        cs_n_s;
   logic        guard_n_s;
   logic        prot_any;
   logic [23:0] prot_lo;
   logic [23:0] prot_hi;
   logic [15:0] live;
   logic [23:0] reg_mask;
   logic        is_array;
   logic        is_quad;
   logic        hit;
   logic        lock_ok;
   logic [23:0] reg_lo;
   logic [23:0] reg_hi;

   // pins cross into the core clock here
   sfsp_sync2 #(
      .W          (3)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .async_i    ({sclk_pin_i, cs_n_pin_i, write_guard_n_pin_i}),
      .sync_o     (pins_s)
   );

   assign sclk_s    = pins_s[2];
   assign cs_n_s    = pins_s[1];
   assign guard_n_s = pins_s[0];

   sfsp_prot_range u_range (
      .gran_i       (r.gran),
      .top_bottom_i (r.top_bottom),
      .level_i      (r.level),
      .invert_i     (r.invert),
      .prot_any_o   (prot_any),
      .prot_lo_o    (prot_lo),
      .prot_hi_o    (prot_hi)
   );

   // live status word; reserved bits stay zero
   always_comb begin
      live       = 16'h0000;
      live[0]    = r.busy;
      live[1]    = r.wrlatch;
      live[4:2]  = r.level;
      live[5]    = r.top_bottom;
      live[6]    = r.gran;
      live[7]    = r.lock0;
      live[8]    = r.lock1;
      live[9]    = r.four_lane;
      live[14]   = r.invert;
      live[15]   = r.paused;
   end

   // region touched by the instruction, rounded to its erase or page unit
   always_comb begin
      is_array = 1'b1;
      reg_mask = MASK_PAGE;
      if (cmd_code_i == OP_ER_4K) begin
         reg_mask = MASK_4K;
      end else if (cmd_code_i == OP_ER_32K) begin
         reg_mask = MASK_32K;
      end else if (cmd_code_i == OP_ER_64K) begin
         reg_mask = MASK_64K;
      end else if (cmd_code_i == OP_ER_CHIP_A || cmd_code_i == OP_ER_CHIP_B) begin
         reg_mask = ADDR_MAX;
      end else if (cmd_code_i != OP_PROG && cmd_code_i != OP_QPROG) begin
         is_array = 1'b0;
      end
      reg_lo = cmd_addr_i & ~reg_mask;
      reg_hi = cmd_addr_i | reg_mask;
      hit    = is_array && prot_any && !(prot_hi < reg_lo || prot_lo > reg_hi);
   end

   // quad-lane instructions gated by the four-lane bit
   assign is_quad = (cmd_code_i == OP_QPROG) || (cmd_code_i == OP_QRD_OUT)
                    || (cmd_code_i == OP_QRD_IO) || (cmd_code_i == OP_QRD_ID)
                    || (cmd_code_i == OP_QRD_WORD) || (cmd_code_i == OP_QWRAP)
                    || (cmd_code_i == OP_FOUR_ON);

   // guard pin loses its function once the pins are data lanes
   assign lock_ok = !r.lock1 && (!r.lock0 || guard_n_s || r.four_lane);

   // next state: completion, instruction handling, status shift-out
   always_comb begin
      next_r         = r;
      next_r.start   = 1'b0;
      next_r.suspend = 1'b0;
      next_r.resume  = 1'b0;
      next_r.ignored = 1'b0;
      next_r.sclk_q  = sclk_s;
      case (r.st)
         ST_STATUS: begin
            if (r.wr_cnt == '0) begin
               next_r.st   = ST_IDLE;
               next_r.busy = 1'b0;
            end else begin
               next_r.wr_cnt = r.wr_cnt - 1'b1;
            end
         end
         ST_ARRAY: begin
            if (op_done_i && !r.paused) begin
               next_r.st   = ST_IDLE;
               next_r.busy = 1'b0;
            end
         end
         default: begin
         end
      endcase
      if (cmd_valid_i) begin
         if (cmd_code_i == OP_RD_LO || cmd_code_i == OP_RD_HI) begin
            next_r.rd_on  = 1'b1;
            next_r.rd_hi  = (cmd_code_i == OP_RD_HI);
            next_r.rd_idx = 3'h7;
         end else if (r.busy) begin
            if (cmd_code_i == OP_SUSPEND && r.st == ST_ARRAY && r.op != OP_SECURE_WR) begin
               next_r.paused  = 1'b1;
               next_r.busy    = 1'b0;
               next_r.suspend = 1'b1;
            end else begin
               next_r.ignored = 1'b1;
            end
         end else if (cmd_code_i == OP_RESUME) begin
            if (r.paused) begin
               next_r.paused = 1'b0;
               next_r.busy   = 1'b1;
               next_r.resume = 1'b1;
            end else begin
               next_r.ignored = 1'b1;
            end
         end else if (is_quad && !r.four_lane) begin
            next_r.ignored = 1'b1;
            if (cmd_code_i == OP_QPROG) begin
               next_r.wrlatch = 1'b0;
            end
         end else if (cmd_code_i == OP_WREN) begin
            next_r.wrlatch = 1'b1;
         end else if (cmd_code_i == OP_WRDI) begin
            next_r.wrlatch = 1'b0;
         end else if (cmd_code_i == OP_FOUR_ON) begin
            next_r.quad_cmds = 1'b1;
         end else if (cmd_code_i == OP_FOUR_OFF) begin
            next_r.quad_cmds = 1'b0;
         end else if (cmd_code_i == OP_WR_STAT || cmd_code_i == OP_WR_HI) begin
            next_r.wrlatch = 1'b0;
            if (r.wrlatch && lock_ok && !r.paused) begin
               if (cmd_code_i == OP_WR_STAT) begin
                  next_r.level      = cmd_data_i[4:2];
                  next_r.top_bottom = cmd_data_i[5];
                  next_r.gran       = cmd_data_i[6];
                  next_r.lock0      = cmd_data_i[7];
               end
               if (cmd_code_i == OP_WR_HI || cmd_two_bytes_i) begin
                  next_r.lock1     = (cmd_code_i == OP_WR_HI) ? cmd_data_i[0] : cmd_data_i[8];
                  next_r.four_lane = (cmd_code_i == OP_WR_HI) ? cmd_data_i[1] : cmd_data_i[9];
                  next_r.invert    = (cmd_code_i == OP_WR_HI) ? cmd_data_i[6] : cmd_data_i[14];
               end
               next_r.st     = ST_STATUS;
               next_r.busy   = 1'b1;
               next_r.wr_cnt = SWR_CNT_W'(SWR_CYCLES - 1);
            end else begin
               next_r.ignored = 1'b1;
            end
         end else if (is_array || cmd_code_i == OP_SECURE_WR) begin
            next_r.wrlatch = 1'b0;
            if (r.wrlatch && !hit && !r.paused) begin
               next_r.st    = ST_ARRAY;
               next_r.busy  = 1'b1;
               next_r.start = 1'b1;
               next_r.op    = cmd_code_i;
               next_r.addr  = cmd_addr_i;
            end else begin
               next_r.ignored = 1'b1;
            end
         end
      end
      // shift-out walks bits on falling serial clock, wrapping to repeat
      if (cs_n_s) begin
         next_r.rd_on = 1'b0;
         next_r.so_oe = 1'b0;
      end else begin
         next_r.so_oe = next_r.rd_on;
         if (r.rd_on && r.sclk_q && !sclk_s) begin
            next_r.rd_idx = r.rd_idx - 1'b1;
         end
         next_r.so = r.rd_hi ? live[8 + next_r.rd_idx] : live[next_r.rd_idx];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= RESET_STATE;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // all outputs are flop bits
   assign status_o         = live;
   assign array_start_o    = r.start;
   assign array_op_o       = r.op;
   assign array_addr_o     = r.addr;
   assign array_suspend_o  = r.suspend;
   assign array_resume_o   = r.resume;
   assign cmd_ignored_o    = r.ignored;
   assign four_lane_mode_o = r.quad_cmds;
   assign so_o             = r.so;
   assign so_oe_o          = r.so_oe;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   logic take;
   assign take = ce_i && cmd_valid_i;

   AST_BUSY_WITH_START:
   assert property (array_start_o |-> status_o[0] && r.st == ST_ARRAY)
      else $error("array start without in-progress flag");
   AST_IGNORE_BUSY:
   assert property (take && r.busy && cmd_code_i == OP_PROG |=> !array_start_o && cmd_ignored_o)
      else $error("program taken while in progress");
   AST_STATUS_DONE:
   assert property (ce_i && r.st == ST_STATUS && r.wr_cnt == '0 |=> !status_o[0])
      else $error("status write did not finish");
   AST_LATCH_SET:
   assert property (take && !r.busy && cmd_code_i == OP_WREN |=> status_o[1])
      else $error("write latch not set");
   AST_LATCH_CLR:
   assert property (take && !r.busy && (cmd_code_i == OP_WRDI || is_array) |=> !status_o[1])
      else $error("write latch not cleared");
   AST_GUARD_LOW:
   assert property (take && !r.busy && cmd_code_i == OP_WR_STAT && !r.lock1 && r.lock0
                    && !guard_n_s && !r.four_lane |=> !status_o[0] && $stable(status_o[9:2]))
      else $error("status write passed low guard pin");
   AST_LOCKED:
   assert property (take && !r.busy && r.lock1 && (cmd_code_i == OP_WR_STAT || cmd_code_i == OP_WR_HI)
                    |=> !status_o[0] && $stable(status_o[14:2]))
      else $error("status write passed lock");
   AST_PROTECTED:
   assert property (take && !r.busy && hit |=> !array_start_o)
      else $error("protected region started");
   AST_PAUSE:
   assert property (array_suspend_o |-> status_o[15] && !status_o[0])
      else $error("suspend did not set paused flag");
   AST_QUAD_GATE:
   assert property (take && cmd_code_i == OP_FOUR_ON && !r.four_lane |=> $stable(four_lane_mode_o))
      else $error("four-lane entry without enable bit");
   AST_RESERVED:
   assert property (status_o[13:10] == 4'h0)
      else $error("reserved bits nonzero");

   COV_STATUS_WR: cover property ($rose(status_o[0]) && r.st == ST_STATUS);
   COV_ARRAY: cover property (array_start_o ##[1:50] !status_o[0]);
   COV_SUSPEND: cover property (array_suspend_o ##[1:50] array_resume_o);
   COV_READ: cover property (so_oe_o [*8]);

endmodule

// ### verif/sfsp_host_model.sv
// sfsp_host_model: host end of the serial status pins
// assumes: the bench frames each status read with sel and clk calls
`timescale 1ns/10ps
module sfsp_host_model (
   input  wire logic so_i,
   input  wire logic so_oe_i,
   output logic      sclk_o,
   output logic      cs_n_o
);
   logic [15:0] rx;
   // mode 0: clock stands low outside frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      rx     = 16'h0000;
   end
   // settle time lets the synchronised select reach the core first
   task automatic sel(input logic lvl);
      cs_n_o = lvl;
      #200;
   endtask
   // sample on rising edges, the device shifts on falling ones
   task automatic clk(input int n);
      for (int i = 0; i < n; i++) begin
         #32 sclk_o = 1'b1;
         rx = {rx[14:0], so_oe_i & so_i};
         #32 sclk_o = 1'b0;
      end
   endtask
endmodule

// ### verif/testbench.sv
// testbench: drives sfsp_core through its instruction port and pins
// assumes: 200 MHz core clock, host model owning select and serial clock
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t %h %h", $time, (a), (b)); end end
module testbench;
   import sfsp_pkg::*;
   typedef struct {logic [15:0] st; logic [23:0] bad; logic [23:0] good;} sfsp_case_t;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cmd_valid_i = 1'b0;
   logic [7:0]  cmd_code_i = 8'h00;
   logic [23:0] cmd_addr_i = 24'h00_0000;
   logic [15:0] cmd_data_i = 16'h0000;
   logic        cmd_two_bytes_i = 1'b0;
   logic        op_done_i = 1'b0;
   logic        write_guard_n_pin_i = 1'b0;
   logic        sclk, cs_n, so, so_oe, start, ign, susp, resm, four, s_start, s_ign;
   logic [15:0] status;
   logic [7:0]  aop;
   logic [23:0] aaddr;
   int          checked = 0;
   int          mismatches = 0;
   // status value, an address refused, an address accepted
   sfsp_case_t  cases [5] = '{
      '{16'h0004, 24'hFC_0000, 24'hFB_FF00},
      '{16'h004C, 24'hFF_C000, 24'hFF_BF00},
      '{16'h0074, 24'h00_7F00, 24'h00_8000},
      '{16'h0038, 24'h7F_FF00, 24'h80_0000},
      '{16'h4004, 24'hFB_FF00, 24'hFC_0000}};

   sfsp_core i_sfsp_core (.core_clk_i, .rst_i, .ce_i(1'b1), .cmd_valid_i, .cmd_code_i,
      .cmd_addr_i, .cmd_data_i, .cmd_two_bytes_i, .op_done_i, .sclk_pin_i(sclk),
      .cs_n_pin_i(cs_n), .write_guard_n_pin_i, .status_o(status), .array_start_o(start),
      .array_op_o(aop), .array_addr_o(aaddr), .array_suspend_o(susp),
      .array_resume_o(resm), .cmd_ignored_o(ign), .four_lane_mode_o(four), .so_o(so),
      .so_oe_o(so_oe));
   sfsp_host_model i_sfsp_host_model (.so_i(so), .so_oe_i(so_oe), .sclk_o(sclk),
      .cs_n_o(cs_n));

   always #2.5 core_clk_i = ~core_clk_i;

   // one instruction; one-cycle answers are caught in the cycle after
   task automatic cmd(input logic [7:0] c, input logic [23:0] a = 24'h00_0000,
                      input logic [15:0] d = 16'h0000);
      @(negedge core_clk_i);
      cmd_valid_i = 1'b1;
      cmd_code_i = c;
      cmd_addr_i = a;
      cmd_data_i = d;
      cmd_two_bytes_i = 1'b1;
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      s_start = start;
      s_ign = ign;
   endtask
   task automatic wcmd(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d);
      cmd(OP_WREN);
      cmd(c, a, d);
   endtask
   task automatic idle;
      for (int i = 0; i < 200 && status[0] !== 1'b0; i++) @(negedge core_clk_i);
   endtask
   task automatic wst(input logic [7:0] c, input logic [15:0] d);
      wcmd(c, 24'h00_0000, d);
      idle();
   endtask
   task automatic done;
      op_done_i = 1'b1;
      @(negedge core_clk_i);
      op_done_i = 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic rst;
      rst_i = 1'b1;
      repeat (20) @(negedge core_clk_i);
      rst_i = 1'b0;
   endtask
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      rst();
      `CHK(status, 16'h0000)
      cmd(OP_WREN);
      `CHK(status[1], 1'b1)
      cmd(OP_WRDI);
      `CHK(status[1], 1'b0)
      cmd(OP_FOUR_ON);
      `CHK({s_ign, four}, 2'b10)
      foreach (cases[k]) begin
         wcmd(OP_WR_STAT, 24'h00_0000, cases[k].st);
         `CHK(status[1:0], 2'b01)
         idle();
         `CHK(status, cases[k].st)
         wcmd(OP_PROG, cases[k].bad, 16'h0000);
         `CHK({s_start, s_ign, status[1]}, 3'b010)
         wcmd(OP_PROG, cases[k].good, 16'h0000);
         `CHK({s_start, aaddr, status[1:0]}, {1'b1, cases[k].good, 2'b01})
         cmd(OP_WREN);
         `CHK({s_ign, status[1]}, 2'b10)
         done();
         `CHK(status[0], 1'b0)
      end
      wcmd(OP_PROG, 24'hFC_0000, 16'h0000);
      cmd(OP_SUSPEND);
      `CHK({status[15], susp}, 2'b11)
      cmd(OP_RESUME);
      `CHK({status[15], status[0], resm}, 3'b011)
      done();
      wcmd(OP_QPROG, 24'hFC_0000, 16'h0000);
      `CHK({s_start, s_ign, status[1]}, 3'b010)
      wcmd(OP_ER_32K, 24'hFB_8000, 16'h0000);
      `CHK({s_start, s_ign}, 2'b01)
      wcmd(OP_ER_64K, 24'hFC_8000, 16'h0000);
      `CHK({s_start, aop, aaddr}, {1'b1, OP_ER_64K, 24'hFC_8000})
      done();
      wcmd(OP_SECURE_WR, 24'h00_0000, 16'h0000);
      cmd(OP_SUSPEND);
      `CHK({s_ign, status[15], status[0]}, 3'b101)
      done();
      for (int k = 0; k < 2; k++) begin
         i_sfsp_host_model.sel(1'b0);
         cmd(k ? OP_RD_HI : OP_RD_LO);
         `CHK(so_oe, 1'b1)
         i_sfsp_host_model.clk(16);
         i_sfsp_host_model.sel(1'b1);
         `CHK({so_oe, i_sfsp_host_model.rx}, {1'b0, k ? 16'h4040 : 16'h0404})
      end
      // guard pin is driven by the bench, never tied off
      wst(OP_WR_STAT, 16'h7E00);
      `CHK(status, 16'h4200)
      cmd(OP_FOUR_ON);
      `CHK(four, 1'b1)
      cmd(OP_FOUR_OFF);
      `CHK(four, 1'b0)
      wst(OP_WR_STAT, 16'h0080);
      wst(OP_WR_STAT, 16'h0084);
      `CHK(status, 16'h0080)
      write_guard_n_pin_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      wst(OP_WR_STAT, 16'h0084);
      `CHK(status, 16'h0084)
      wst(OP_WR_HI, 16'h0001);
      wst(OP_WR_STAT, 16'h0000);
      `CHK(status, 16'h0184)
      rst();
      wst(OP_WR_HI, 16'h0001);
      wst(OP_WR_STAT, 16'h0004);
      `CHK(status, 16'h0100)
      rst();
      `CHK(status, 16'h0000)
      complete_run();
   end

   // watchdog, far beyond the expected run length
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule
